// >>> verilog/uartc_core.sv
// Serial port line, modem and FIFO control with register port
//
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/100ps
// Functional notes
// - Parity select one gives even ones over data and parity, zero odd.
// - Parity enable inserts and checks a parity bit after the data bits.
// - Extra stop: 1.5 stop bits for 5-bit data, two otherwise.
// - Two-bit length field selects five to eight data bits.
// - Error summary zero without FIFO; clears on status read once no errors.
// - Transmitter idle only when shift register and holding/FIFO empty.
// - Holding-empty sets when holding/FIFO empties, clears on data write.
// - Silent-line flag for a full all-zero character, head entry in FIFO.
// - Missing-stop and parity error flags, describing the FIFO head entry.
// - Line status read clears overrun, parity, missing-stop, silent-line.
// - Overrun sets when an unread character is overwritten or lost.
// - Receive-ready is one while receive buffer or FIFO holds data.
// - Loopback holds output high, cuts input pin, request and ready outputs inactive.
// - Loopback feeds modem inputs from modem control bits.
// - Modem control bit 3 enables interrupt output; bit 2 only loops ring.
// - Modem control bits 1 and 0 drive inverted request and ready pins.
// - Modem status high nibble is inverted inputs, or control in loopback.
// - Change flags on carrier, ready, clear toggles and ring pin rising.
// - Trigger field selects 1, 4, 8 or 14 byte receive threshold.
// - DMA bit selects mode 1 only while FIFO mode is on.
// - FIFO reset bits clear counters and return to zero themselves.
// - FIFO enable bit turns on FIFO mode; software sets it first.
module uartc_core #(
  parameter int DEPTH = 16,
  parameter int AW = 4,
  parameter int BAUD_DIV = 22
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [2:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic serial_in,
  output logic serial_out,
  input wire logic cts_n_in,
  input wire logic dsr_n_in,
  input wire logic ri_n_in,
  input wire logic dcd_n_in,
  output logic rts_n_out,
  output logic dtr_n_out,
  output logic irq_enable_out,
  output logic rx_trigger_out,
  output logic dma_mode_out
);
  localparam logic [AW:0] CAP_F = (AW + 1)'(DEPTH);
  localparam logic [AW:0] CAP_1 = (AW + 1)'(1);
  localparam logic [15:0] DIV_END = 16'(BAUD_DIV - 1);

  // Data mask for the selected length
  function automatic logic [7:0] len_mask(input logic [1:0] len);
    len_mask = 8'hFF >> (2'h3 - len);
  endfunction

  // Parity bit for data of given length and sense
  function automatic logic par_bit(input logic [7:0] d,
    input logic [1:0] len, input logic even);
    par_bit = even ? ^(d & len_mask(len)) : ~^(d & len_mask(len));
  endfunction

  // Index of the last data bit
  function automatic logic [2:0] last_bit(input logic [1:0] len);
    last_bit = uartc_pkg::BIT_BASE + {1'b0, len};
  endfunction

  // Register port decode
  logic wr_dat, rd_dat, wr_fifo, rd_ls, rd_ms;
  assign wr_dat = wr_in && addr_in == uartc_pkg::A_DATA;
  assign rd_dat = rd_in && addr_in == uartc_pkg::A_DATA;
  assign wr_fifo = wr_in && addr_in == uartc_pkg::A_FIFO;
  assign rd_ls = rd_in && addr_in == uartc_pkg::A_LS;
  assign rd_ms = rd_in && addr_in == uartc_pkg::A_MS;

  // Control, modem and output state
  logic [7:0] lfc_r, lfc_nxt, rdata_r, rdata_nxt;
  logic [4:0] mc_r, mc_nxt;
  logic fen_r, fen_nxt, dma_r, dma_nxt;
  logic [1:0] trig_r, trig_nxt;
  logic [3:0] ms_prev_r, ms_prev_nxt, ms_chg_r, ms_chg_nxt, ms_cur;
  logic serial_output_pin_r, serial_output_pin_nxt, rts_n_r, rts_n_nxt, dtr_n_r, dtr_n_nxt;
  logic irqen_r, irqen_nxt, trig_hit_r, trig_hit_nxt, dmao_r, dmao_nxt;
  logic [15:0] bd_r, bd_nxt;
  logic tick, tx_rst, rx_rst, loop;
  logic [4:0] trig_lvl;
  logic [AW:0] cap;
  // Status bits shared with the data path
  logic ls_oe_r, ls_pe_r, ls_fe_r, ls_bk_r, ls_sum_r;
  logic [AW:0] tx_cnt_r, rx_cnt_r;
  logic [AW-1:0] rx_rp_r;
  logic [10:0] rx_mem [DEPTH];
  uartc_pkg::uartc_tx_t tx_st_r, tx_st_nxt;
  logic tx_line_r;

  assign loop = mc_r[uartc_pkg::B_LOOP];
  assign cap = fen_r ? CAP_F : CAP_1;
  assign tick = bd_r == DIV_END;

  // Control register writes, modem tracking and read mux
  always_comb
  begin
    lfc_nxt = lfc_r;
    mc_nxt = mc_r;
    fen_nxt = fen_r;
    dma_nxt = dma_r;
    trig_nxt = trig_r;
    tx_rst = 1'b0;
    rx_rst = 1'b0;
    bd_nxt = tick ? 16'h0000 : bd_r + 16'h0001;
    if (wr_in && addr_in == uartc_pkg::A_LFC)
      lfc_nxt = wdata_in;
    if (wr_in && addr_in == uartc_pkg::A_MC)
      mc_nxt = wdata_in[4:0];
    if (wr_fifo)
    begin
      fen_nxt = wdata_in[uartc_pkg::B_FEN];
      dma_nxt = wdata_in[uartc_pkg::B_DMA];
      trig_nxt = wdata_in[uartc_pkg::TRIG_LO +: 2];
      // Self-clearing resets, also on a mode change
      tx_rst = wdata_in[uartc_pkg::B_TXRST] || fen_nxt != fen_r;
      rx_rst = wdata_in[uartc_pkg::B_RXRST] || fen_nxt != fen_r;
    end
    // Modem inputs: dcd, ri, dsr, cts
    if (loop)
      ms_cur = {mc_r[uartc_pkg::B_IRQEN], mc_r[uartc_pkg::B_RILB],
        mc_r[uartc_pkg::B_DTR], mc_r[uartc_pkg::B_RTS]};
    else
      ms_cur = ~{dcd_n_in, ri_n_in, dsr_n_in, cts_n_in};
    ms_prev_nxt = ms_cur;
    // Set wins over the read clear
    ms_chg_nxt = (ms_chg_r & {4{~rd_ms}})
      | {ms_cur[3] ^ ms_prev_r[3], ms_prev_r[2] & ~ms_cur[2],
      ms_cur[1:0] ^ ms_prev_r[1:0]};
    case (trig_r)
      2'h0: trig_lvl = uartc_pkg::TRIG_1;
      2'h1: trig_lvl = uartc_pkg::TRIG_4;
      2'h2: trig_lvl = uartc_pkg::TRIG_8;
      default: trig_lvl = uartc_pkg::TRIG_14;
    endcase
    trig_hit_nxt = fen_r ? (rx_cnt_r >= trig_lvl)
      : rx_cnt_r != '0;
    dmao_nxt = fen_r && dma_r;
    serial_output_pin_nxt = loop | tx_line_r;
    rts_n_nxt = loop | ~mc_r[uartc_pkg::B_RTS];
    dtr_n_nxt = loop | ~mc_r[uartc_pkg::B_DTR];
    irqen_nxt = mc_r[uartc_pkg::B_IRQEN];
    rdata_nxt = 8'h00;
    if (rd_in)
      case (addr_in)
        uartc_pkg::A_DATA: rdata_nxt = rx_mem[rx_rp_r][7:0];
        uartc_pkg::A_LFC: rdata_nxt = lfc_r;
        uartc_pkg::A_MC: rdata_nxt = {3'h0, mc_r};
        uartc_pkg::A_LS: rdata_nxt = {ls_sum_r,
          tx_cnt_r == '0 && tx_st_r == uartc_pkg::TX_IDLE,
          tx_cnt_r == '0, ls_bk_r, ls_fe_r, ls_pe_r, ls_oe_r,
          rx_cnt_r != '0};
        uartc_pkg::A_MS: rdata_nxt = {ms_cur, ms_chg_r};
        default: rdata_nxt = 8'h00;
      endcase
  end

  // Control registers
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      lfc_r <= uartc_pkg::LFC_RST;
      mc_r <= uartc_pkg::MC_RST;
      fen_r <= 1'b0;
      dma_r <= 1'b0;
      trig_r <= 2'h0;
      ms_prev_r <= 4'h0;
      ms_chg_r <= 4'h0;
      bd_r <= 16'h0000;
      rdata_r <= 8'h00;
      serial_output_pin_r <= 1'b1;
      rts_n_r <= 1'b1;
      dtr_n_r <= 1'b1;
      irqen_r <= 1'b0;
      trig_hit_r <= 1'b0;
      dmao_r <= 1'b0;
    end
    else
    begin
      lfc_r <= lfc_nxt;
      mc_r <= mc_nxt;
      fen_r <= fen_nxt;
      dma_r <= dma_nxt;
      trig_r <= trig_nxt;
      ms_prev_r <= ms_prev_nxt;
      ms_chg_r <= ms_chg_nxt;
      bd_r <= bd_nxt;
      rdata_r <= rdata_nxt;
      serial_output_pin_r <= serial_output_pin_nxt;
      rts_n_r <= rts_n_nxt;
      dtr_n_r <= dtr_n_nxt;
      irqen_r <= irqen_nxt;
      trig_hit_r <= trig_hit_nxt;
      dmao_r <= dmao_nxt;
    end
  end

  // Transmit holding FIFO and shift engine
  logic [7:0] tx_mem [DEPTH];
  logic [AW-1:0] tx_wp_r, tx_wp_nxt, tx_rp_r, tx_rp_nxt;
  logic [AW:0] tx_cnt_nxt;
  logic [7:0] tx_sh_r, tx_sh_nxt;
  logic [5:0] tx_tk_r, tx_tk_nxt, tx_end;
  logic [2:0] tx_bit_r, tx_bit_nxt;
  logic tx_par_r, tx_par_nxt, tx_line_nxt, tx_we, tx_pop;

  always_comb
  begin
    tx_wp_nxt = tx_wp_r;
    tx_rp_nxt = tx_rp_r;
    tx_sh_nxt = tx_sh_r;
    tx_tk_nxt = tx_tk_r;
    tx_bit_nxt = tx_bit_r;
    tx_par_nxt = tx_par_r;
    tx_line_nxt = tx_line_r;
    tx_st_nxt = tx_st_r;
    tx_we = wr_dat && tx_cnt_r < cap;
    tx_pop = 1'b0;
    if (!lfc_r[uartc_pkg::B_XSTOP])
      tx_end = uartc_pkg::OS_END;
    else if (lfc_r[uartc_pkg::LEN_LO +: 2] == 2'h0)
      tx_end = uartc_pkg::STOP15_END;
    else
      tx_end = uartc_pkg::STOP2_END;
    if (tx_st_r != uartc_pkg::TX_STOP)
      tx_end = uartc_pkg::OS_END;
    if (tick)
    begin
      tx_tk_nxt = tx_tk_r + 6'h01;
      case (tx_st_r)
        uartc_pkg::TX_IDLE:
          if (tx_cnt_r != '0)
          begin
            tx_pop = 1'b1;
            tx_sh_nxt = tx_mem[tx_rp_r];
            tx_par_nxt = par_bit(tx_mem[tx_rp_r], lfc_r[1:0],
              lfc_r[uartc_pkg::B_PEVEN]);
            tx_rp_nxt = tx_rp_r + 1'b1;
            tx_st_nxt = uartc_pkg::TX_START;
            tx_line_nxt = 1'b0;
            tx_tk_nxt = 6'h00;
          end
        default:
          if (tx_tk_r == tx_end)
          begin
            tx_tk_nxt = 6'h00;
            tx_line_nxt = 1'b1;
            if (tx_st_r == uartc_pkg::TX_START)
            begin
              tx_st_nxt = uartc_pkg::TX_DATA;
              tx_line_nxt = tx_sh_r[0];
              tx_bit_nxt = 3'h0;
            end
            else if (tx_st_r == uartc_pkg::TX_DATA
              && tx_bit_r != last_bit(lfc_r[1:0]))
            begin
              tx_bit_nxt = tx_bit_r + 3'h1;
              tx_sh_nxt = tx_sh_r >> 1;
              tx_line_nxt = tx_sh_r[1];
            end
            else if (tx_st_r == uartc_pkg::TX_DATA
              && lfc_r[uartc_pkg::B_PEN])
            begin
              tx_st_nxt = uartc_pkg::TX_PAR;
              tx_line_nxt = tx_par_r;
            end
            else if (tx_st_r == uartc_pkg::TX_STOP)
              tx_st_nxt = uartc_pkg::TX_IDLE;
            else
              tx_st_nxt = uartc_pkg::TX_STOP;
          end
      endcase
    end
    if (tx_we)
      tx_wp_nxt = tx_wp_r + 1'b1;
    tx_cnt_nxt = tx_cnt_r + (AW + 1)'(tx_we) - (AW + 1)'(tx_pop);
    if (tx_rst)
    begin
      tx_wp_nxt = '0;
      tx_rp_nxt = '0;
      tx_cnt_nxt = '0;
    end
  end

  // Transmit registers
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      tx_wp_r <= '0;
      tx_rp_r <= '0;
      tx_cnt_r <= '0;
      tx_sh_r <= 8'h00;
      tx_tk_r <= 6'h00;
      tx_bit_r <= 3'h0;
      tx_par_r <= 1'b0;
      tx_line_r <= 1'b1;
      tx_st_r <= uartc_pkg::TX_IDLE;
    end
    else
    begin
      if (tx_we)
        tx_mem[tx_wp_r] <= wdata_in;
      tx_wp_r <= tx_wp_nxt;
      tx_rp_r <= tx_rp_nxt;
      tx_cnt_r <= tx_cnt_nxt;
      tx_sh_r <= tx_sh_nxt;
      tx_tk_r <= tx_tk_nxt;
      tx_bit_r <= tx_bit_nxt;
      tx_par_r <= tx_par_nxt;
      tx_line_r <= tx_line_nxt;
      tx_st_r <= tx_st_nxt;
    end
  end

  // Receive engine, receive FIFO and line status flags
  uartc_pkg::uartc_rx_t rx_st_r, rx_st_nxt;
  logic [AW-1:0] rx_wp_r, rx_wp_nxt, rx_rp_nxt;
  logic [AW:0] rx_cnt_nxt, err_cnt_r, err_cnt_nxt;
  logic [7:0] rx_sh_r, rx_sh_nxt, rx_data;
  logic [5:0] rx_tk_r, rx_tk_nxt;
  logic [2:0] rx_bit_r, rx_bit_nxt;
  logic rx_pe_r, rx_pe_nxt, rx_fe_r, rx_fe_nxt, rx_z_r, rx_z_nxt;
  logic rxd, rx_push, rx_we, rx_pop, ovw, hd_evt;
  logic [10:0] entry, hd_val;
  logic ls_oe_nxt, ls_pe_nxt, ls_fe_nxt, ls_bk_nxt, ls_sum_nxt;

  assign rxd = loop ? tx_line_r : serial_in;
  assign rx_data = (rx_sh_r >> (2'h3 - lfc_r[1:0]));

  always_comb
  begin
    rx_st_nxt = rx_st_r;
    rx_sh_nxt = rx_sh_r;
    rx_tk_nxt = rx_tk_r;
    rx_bit_nxt = rx_bit_r;
    rx_pe_nxt = rx_pe_r;
    rx_fe_nxt = rx_fe_r;
    rx_z_nxt = rx_z_r;
    rx_push = 1'b0;
    entry = {rx_z_r & ~rxd, rx_fe_r | ~rxd, rx_pe_r, rx_data};
    if (tick)
    begin
      rx_tk_nxt = rx_tk_r + 6'h01;
      case (rx_st_r)
        uartc_pkg::RX_IDLE:
          if (!rxd)
          begin
            rx_st_nxt = uartc_pkg::RX_START;
            rx_tk_nxt = 6'h00;
          end
        uartc_pkg::RX_START:
          if (rx_tk_r == uartc_pkg::HALF_END)
          begin
            rx_st_nxt = rxd ? uartc_pkg::RX_IDLE : uartc_pkg::RX_DATA;
            rx_tk_nxt = 6'h00;
            rx_bit_nxt = 3'h0;
            rx_z_nxt = 1'b1;
            rx_pe_nxt = 1'b0;
            rx_fe_nxt = 1'b0;
          end
        uartc_pkg::RX_DATA:
          if (rx_tk_r == uartc_pkg::OS_END)
          begin
            rx_tk_nxt = 6'h00;
            rx_sh_nxt = {rxd, rx_sh_r[7:1]};
            rx_z_nxt = rx_z_r & ~rxd;
            rx_bit_nxt = rx_bit_r + 3'h1;
            if (rx_bit_r == last_bit(lfc_r[1:0]))
              rx_st_nxt = lfc_r[uartc_pkg::B_PEN] ? uartc_pkg::RX_PAR
                : uartc_pkg::RX_STOP;
          end
        uartc_pkg::RX_PAR:
          if (rx_tk_r == uartc_pkg::OS_END)
          begin
            rx_tk_nxt = 6'h00;
            rx_z_nxt = rx_z_r & ~rxd;
            rx_pe_nxt = rxd != par_bit(rx_data, lfc_r[1:0],
              lfc_r[uartc_pkg::B_PEVEN]);
            rx_st_nxt = uartc_pkg::RX_STOP;
          end
        uartc_pkg::RX_STOP:
          if (rx_tk_r == uartc_pkg::OS_END && lfc_r[uartc_pkg::B_XSTOP]
            && lfc_r[1:0] != 2'h0)
          begin
            rx_fe_nxt = rx_fe_r | ~rxd;
            rx_z_nxt = rx_z_r & ~rxd;
          end
          else if (rx_tk_r == uartc_pkg::OS_END
            || rx_tk_r == uartc_pkg::STOP2_END)
          begin
            rx_push = 1'b1;
            rx_st_nxt = entry[uartc_pkg::E_BK] ? uartc_pkg::RX_HOLD
              : uartc_pkg::RX_IDLE;
          end
        uartc_pkg::RX_HOLD:
          if (rxd)
            rx_st_nxt = uartc_pkg::RX_IDLE;
        default: rx_st_nxt = uartc_pkg::RX_IDLE;
      endcase
    end
    // FIFO or single buffer bookkeeping
    rx_pop = rd_dat && rx_cnt_r != '0;
    ovw = rx_push && rx_cnt_r == cap && !rx_pop;
    rx_we = rx_push && (!ovw || !fen_r);
    rx_wp_nxt = rx_wp_r;
    rx_rp_nxt = rx_rp_r + (AW)'(rx_pop);
    rx_cnt_nxt = rx_cnt_r + (AW + 1)'(rx_push && !ovw)
      - (AW + 1)'(rx_pop);
    if (rx_we && !ovw)
      rx_wp_nxt = rx_wp_r + 1'b1;
    err_cnt_nxt = err_cnt_r
      + (AW + 1)'(fen_r && rx_we && !ovw && |entry[10:8])
      - (AW + 1)'(rx_pop && |rx_mem[rx_rp_r][10:8]);
    // New head entry whose error bits become visible
    hd_evt = 1'b1;
    hd_val = entry;
    if (rx_pop && rx_cnt_r > CAP_1)
      hd_val = rx_mem[rx_rp_r + 1'b1];
    else if (!(rx_we && (rx_cnt_r == '0 || ovw || rx_pop)))
      hd_evt = 1'b0;
    // Set wins over the read clear
    ls_oe_nxt = (rx_push && ovw) || (ls_oe_r && !rd_ls);
    ls_pe_nxt = (hd_evt && hd_val[uartc_pkg::E_PE])
      || (ls_pe_r && !rd_ls);
    ls_fe_nxt = (hd_evt && hd_val[uartc_pkg::E_FE])
      || (ls_fe_r && !rd_ls);
    ls_bk_nxt = (hd_evt && hd_val[uartc_pkg::E_BK])
      || (ls_bk_r && !rd_ls);
    if (rx_rst)
    begin
      rx_wp_nxt = '0;
      rx_rp_nxt = '0;
      rx_cnt_nxt = '0;
      err_cnt_nxt = '0;
    end
    ls_sum_nxt = fen_nxt && ((err_cnt_nxt != '0 && !ls_sum_r)
      || (ls_sum_r && !(rd_ls && err_cnt_nxt == '0)));
  end

  // Receive registers
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      rx_st_r <= uartc_pkg::RX_IDLE;
      rx_wp_r <= '0;
      rx_rp_r <= '0;
      rx_cnt_r <= '0;
      err_cnt_r <= '0;
      rx_sh_r <= 8'h00;
      rx_tk_r <= 6'h00;
      rx_bit_r <= 3'h0;
      rx_pe_r <= 1'b0;
      rx_fe_r <= 1'b0;
      rx_z_r <= 1'b0;
      ls_oe_r <= 1'b0;
      ls_pe_r <= 1'b0;
      ls_fe_r <= 1'b0;
      ls_bk_r <= 1'b0;
      ls_sum_r <= 1'b0;
    end
    else
    begin
      if (rx_we)
        rx_mem[ovw ? rx_rp_r : rx_wp_r] <= entry;
      rx_st_r <= rx_st_nxt;
      rx_wp_r <= rx_wp_nxt;
      rx_rp_r <= rx_rp_nxt;
      rx_cnt_r <= rx_cnt_nxt;
      err_cnt_r <= err_cnt_nxt;
      rx_sh_r <= rx_sh_nxt;
      rx_tk_r <= rx_tk_nxt;
      rx_bit_r <= rx_bit_nxt;
      rx_pe_r <= rx_pe_nxt;
      rx_fe_r <= rx_fe_nxt;
      rx_z_r <= rx_z_nxt;
      ls_oe_r <= ls_oe_nxt;
      ls_pe_r <= ls_pe_nxt;
      ls_fe_r <= ls_fe_nxt;
      ls_bk_r <= ls_bk_nxt;
      ls_sum_r <= ls_sum_nxt;
    end
  end

  // Outputs straight from registers
  assign rdata_out = rdata_r;
  assign serial_out = serial_output_pin_r;
  assign rts_n_out = rts_n_r;
  assign dtr_n_out = dtr_n_r;
  assign irq_enable_out = irqen_r;
  assign rx_trigger_out = trig_hit_r;
  assign dma_mode_out = dmao_r;
endmodule // uartc_core

// >>> verilog/uartc_pkg.sv
// Shared constants and types of the serial port control block
package uartc_pkg;
  // Register addresses on the plain register port
  localparam logic [2:0] A_DATA = 3'h0;
  localparam logic [2:0] A_FIFO = 3'h2;
  localparam logic [2:0] A_LFC = 3'h3;
  localparam logic [2:0] A_MC = 3'h4;
  localparam logic [2:0] A_LS = 3'h5;
  localparam logic [2:0] A_MS = 3'h6;
  // Line format control fields
  localparam int LEN_LO = 0;
  localparam int B_XSTOP = 2;
  localparam int B_PEN = 3;
  localparam int B_PEVEN = 4;
  // Modem control fields
  localparam int B_DTR = 0;
  localparam int B_RTS = 1;
  localparam int B_RILB = 2;
  localparam int B_IRQEN = 3;
  localparam int B_LOOP = 4;
  // FIFO control fields
  localparam int B_FEN = 0;
  localparam int B_RXRST = 1;
  localparam int B_TXRST = 2;
  localparam int B_DMA = 3;
  localparam int TRIG_LO = 6;
  // Receive entry error fields above the 8 data bits
  localparam int E_PE = 8;
  localparam int E_FE = 9;
  localparam int E_BK = 10;
  // Reset values
  localparam logic [7:0] LFC_RST = 8'h00;
  localparam logic [4:0] MC_RST = 5'h00;
  // Receive trigger levels in bytes
  localparam logic [4:0] TRIG_1 = 5'h01;
  localparam logic [4:0] TRIG_4 = 5'h04;
  localparam logic [4:0] TRIG_8 = 5'h08;
  localparam logic [4:0] TRIG_14 = 5'h0E;
  // Ticks of the 16x clock, as last index of each span
  localparam logic [5:0] OS_END = 6'h0F;
  localparam logic [5:0] HALF_END = 6'h07;
  localparam logic [5:0] STOP15_END = 6'h17;
  localparam logic [5:0] STOP2_END = 6'h1F;
  localparam logic [2:0] BIT_BASE = 3'h4;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP}
    uartc_tx_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP,
    RX_HOLD} uartc_rx_t;
endpackage

// >>> verification/uartc_core_properties.sv
// Port checks of the serial port control block
`timescale 1ns/100ps
module uartc_core_properties (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [2:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic serial_out,
  input wire logic rts_n_out,
  input wire logic dtr_n_out,
  input wire logic irq_enable_out,
  input wire logic rx_trigger_out,
  input wire logic dma_mode_out
);
  // One clock domain, quiet while reset is high
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);
  a_rts_drive: assert property (
    wr_in && addr_in == uartc_pkg::A_MC |->
    ##2 rts_n_out == ($past(wdata_in[4], 2) | ~$past(wdata_in[1], 2)))
    else $error("rts pin wrong");
  a_dtr_drive: assert property (
    wr_in && addr_in == uartc_pkg::A_MC |->
    ##2 dtr_n_out == ($past(wdata_in[4], 2) | ~$past(wdata_in[0], 2)))
    else $error("dtr pin wrong");
  a_irq_enable: assert property (
    wr_in && addr_in == uartc_pkg::A_MC |->
    ##2 irq_enable_out == $past(wdata_in[3], 2))
    else $error("irq out wrong");
  a_dma_select: assert property (
    wr_in && addr_in == uartc_pkg::A_FIFO |->
    ##2 dma_mode_out == ($past(wdata_in[0], 2) & $past(wdata_in[3], 2)))
    else $error("dma mode output wrong");
  a_loop_high: assert property (
    wr_in && addr_in == uartc_pkg::A_MC && wdata_in[4] |->
    ##2 serial_out [*8])
    else $error("loop out low");
  a_status_clear: assert property (
    (rd_in && addr_in == uartc_pkg::A_LS) ##1
    (rd_in && addr_in == uartc_pkg::A_LS) |=> rdata_out[4:1] == 4'h0)
    else $error("flags not cleared");
  a_change_clear: assert property (
    (rd_in && addr_in == uartc_pkg::A_MS) ##1
    (rd_in && addr_in == uartc_pkg::A_MS) |=> rdata_out[3:0] == 4'h0)
    else $error("changes not cleared");
  a_bit_width: assert property (
    $changed(serial_out) |=> $stable(serial_out) [*8])
    else $error("bit too short");
  a_trig_reset: assert property (
    wr_in && addr_in == uartc_pkg::A_FIFO && wdata_in[1:0] == 2'h3 |->
    ##2 !rx_trigger_out)
    else $error("trigger not cleared");
  a_fifo_zero: assert property (
    rd_in && addr_in == uartc_pkg::A_FIFO |=> rdata_out == 8'h00)
    else $error("fifo reg not zero");
endmodule // uartc_core_properties

// >>> verification/uartc_peer.sv
// Remote serial peer and modem pin model
`timescale 1ns/100ps
module uartc_peer #(
  parameter int BD = 2
) (
  input wire logic clk_in,
  input wire logic line_in,
  output logic line_out,
  output logic [3:0] pins_n_out
);
  localparam int BIT = 16 * BD;
  // Idle line high, modem pins inactive
  initial
  begin
    line_out = 1'b1;
    pins_n_out = 4'hF;
  end
  // Pin order carrier, ring, set ready, clear to send
  task automatic pins(input logic [3:0] v);
    @(posedge clk_in);
    pins_n_out <= v;
  endtask
  // One frame, LSB first
  task automatic send(input logic [11:0] b, input int n);
    @(posedge clk_in);
    line_out <= 1'b0;
    repeat (BIT) @(posedge clk_in);
    for (int i = 0; i < n; i++)
    begin
      line_out <= b[i];
      repeat (BIT) @(posedge clk_in);
    end
    line_out <= 1'b1;
  endtask
  // Sample one frame mid-bit
  task automatic get(output logic [11:0] b, input int n);
    b = 12'h000;
    @(negedge line_in);
    repeat (BIT / 2) @(posedge clk_in);
    for (int i = 0; i < n; i++)
    begin
      repeat (BIT) @(posedge clk_in);
      b[i] = line_in;
    end
  endtask
endmodule // uartc_peer

// >>> verification/uartc_core_bench.sv
// Self-checking bench of the serial port control block
`timescale 1ns/100ps
module uartc_core_bench;
  localparam int BD = 2;
  localparam int BIT = 16 * BD;
  typedef struct {logic [7:0] v; logic [7:0] m;} uartc_note_t;
  typedef struct {logic [11:0] b; int n;} uartc_frm_t;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [2:0] addr_in = 3'h0;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic rd_q = 1'b0;
  logic [7:0] rdata_out, lfc, d;
  logic serial_in, serial_out, rts_n_out, dtr_n_out;
  logic irq_enable_out, rx_trigger_out, dma_mode_out;
  logic [3:0] pins_n;
  logic [31:0] seed = 32'h73784C3D;
  int n_mismatch = 0;
  int num_checks = 0;
  int cycles = 0;
  uartc_note_t notes[$];
  uartc_frm_t frames[$];
  uartc_frm_t f;
  uartc_core #(.BAUD_DIV(BD)) uartc_core_i (.*,
    .cts_n_in(pins_n[0]), .dsr_n_in(pins_n[1]), .ri_n_in(pins_n[2]),
    .dcd_n_in(pins_n[3]));
  uartc_peer #(.BD(BD)) uartc_peer_i (.clk_in(clk_in),
    .line_in(serial_out), .line_out(serial_in), .pins_n_out(pins_n));
  always #12.5 clk_in = ~clk_in;
  // Pseudo-random step
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Expected frame bits after the start bit
  function automatic uartc_frm_t frm(input logic [7:0] v, input logic [7:0] c);
    int len;
    logic [11:0] b;
    len = 5 + int'(c[1:0]);
    b = {4'h0, v} & ((12'h001 << len) - 12'h001);
    b[len] = ^b ^ ~c[4];
    b[len + int'(c[3])] = 1'b1;
    return '{b, len + int'(c[3]) + 1};
  endfunction
  task automatic cmp_val(input logic [11:0] g, input logic [11:0] e);
    num_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk_in);
    wr_in <= 1'b1;
    rd_in <= 1'b0;
    addr_in <= a;
    wdata_in <= v;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e,
    input logic [7:0] m);
    @(posedge clk_in);
    rd_in <= 1'b1;
    wr_in <= 1'b0;
    addr_in <= a;
    notes.push_back('{e, m});
  endtask
  task automatic wt(input int n);
    @(posedge clk_in);
    wr_in <= 1'b0;
    rd_in <= 1'b0;
    repeat (n) @(posedge clk_in);
  endtask
  // Peer sends one character, optionally damaged
  task automatic rx(input logic [7:0] v, input logic [11:0] x);
    f = frm(v, lfc);
    uartc_peer_i.send(f.b ^ x, f.n);
    wt(4);
  endtask
  // Modem pins step, then status read
  task automatic ms(input logic [3:0] p, input logic [7:0] e);
    uartc_peer_i.pins(p);
    wt(3);
    rd(uartc_pkg::A_MS, e, 8'hFF);
  endtask
  // Receive, then status twice, data, status
  task automatic chk_rx(input logic [7:0] v, input logic [11:0] x,
    input logic [7:0] e);
    rx(v, x);
    rd(uartc_pkg::A_LS, e, 8'hFF);
    rd(uartc_pkg::A_LS, e & 8'h61, 8'hFF);
    rd(uartc_pkg::A_DATA, v, 8'hFF);
    rd(uartc_pkg::A_LS, 8'h60, 8'hFF);
    wt(1);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Read data monitor against the oldest note
  always @(posedge clk_in)
  begin
    if (rd_q)
    begin
      uartc_note_t n;
      n = notes.pop_front();
      cmp_val({4'h0, rdata_out & n.m}, {4'h0, n.v & n.m});
    end
    rd_q <= rd_in;
  end
  // Frame monitor at the peer
  always
  begin
    logic [11:0] g;
    wait (frames.size() > 0);
    uartc_peer_i.get(g, frames[0].n);
    cmp_val(g, frames.pop_front().b);
  end
  // Hang guard
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      n_mismatch++;
      results();
    end
  end
  initial
  begin
    repeat (2) @(posedge clk_in);
    reset_in <= 1'b0;
    rd(uartc_pkg::A_LS, 8'h60, 8'hFF);
    rd(uartc_pkg::A_MS, 8'h00, 8'hFF);
    rd(uartc_pkg::A_FIFO, 8'h00, 8'hFF);
    rd(3'h7, 8'h00, 8'hFF);
    wt(2);
    cmp_val({9'h0, rts_n_out, dtr_n_out, dma_mode_out}, 12'h006);
    $display("test reset done");
    wr(uartc_pkg::A_MC, 8'h0B);
    wt(3);
    cmp_val({10'h0, rts_n_out, dtr_n_out}, 12'h000);
    ms(4'hC, 8'h33);
    rd(uartc_pkg::A_MS, 8'h30, 8'hFF);
    wt(1);
    ms(4'h8, 8'h70);
    wt(1);
    ms(4'hC, 8'h34);
    wt(1);
    ms(4'h4, 8'hB8);
    wt(1);
    ms(4'hF, 8'h0B);
    wt(1);
    $display("test modem done");
    wr(uartc_pkg::A_LFC, 8'h03);
    wr(uartc_pkg::A_MC, 8'h15);
    wt(3);
    cmp_val({10'h0, rts_n_out, dtr_n_out}, 12'h003);
    rd(uartc_pkg::A_MS, 8'h60, 8'hF0);
    wr(uartc_pkg::A_DATA, 8'hA5);
    wt(BIT * 12);
    rd(uartc_pkg::A_LS, 8'h61, 8'hFF);
    rd(uartc_pkg::A_DATA, 8'hA5, 8'hFF);
    wr(uartc_pkg::A_MC, 8'h00);
    wt(3);
    $display("test loopback done");
    for (int k = 0; k < 8; k++)
    begin
      lfc = {3'h0, k[0] ^ k[1], k[2], k[1], k[1:0]};
      seed = nxt(seed);
      wr(uartc_pkg::A_LFC, lfc);
      frames.push_back(frm(seed[7:0], lfc));
      wr(uartc_pkg::A_DATA, seed[7:0]);
      wt(1);
      wait (frames.size() == 0);
      wt(BIT * 2);
    end
    rd(uartc_pkg::A_LS, 8'h60, 8'hFF);
    wt(1);
    $display("test transmit done");
    lfc = 8'h1B;
    wr(uartc_pkg::A_LFC, lfc);
    wt(1);
    seed = nxt(seed);
    chk_rx(seed[7:0], 12'h000, 8'h61);
    chk_rx(seed[15:8], 12'h100, 8'h65);
    chk_rx(seed[23:16], 12'h200, 8'h69);
    chk_rx(8'h00, 12'h200, 8'h79);
    rx(seed[7:0], 12'h000);
    chk_rx(seed[31:24], 12'h000, 8'h63);
    $display("test receive done");
    wr(uartc_pkg::A_FIFO, 8'h09);
    wt(3);
    cmp_val({11'h0, dma_mode_out}, 12'h001);
    for (int k = 0; k < 3; k++)
    begin
      seed = nxt(seed);
      frames.push_back(frm(seed[7:0], lfc));
      wr(uartc_pkg::A_DATA, seed[7:0]);
    end
    rd(uartc_pkg::A_LS, 8'h00, 8'h60);
    wt(1);
    wait (frames.size() == 0);
    wt(BIT * 2);
    rd(uartc_pkg::A_LS, 8'h60, 8'h60);
    wt(1);
    d = seed[15:8];
    rx(seed[7:0], 12'h000);
    rx(d, 12'h100);
    rd(uartc_pkg::A_LS, 8'hE1, 8'hFF);
    rd(uartc_pkg::A_DATA, seed[7:0], 8'hFF);
    rd(uartc_pkg::A_LS, 8'hE5, 8'hFF);
    rd(uartc_pkg::A_DATA, d, 8'hFF);
    rd(uartc_pkg::A_LS, 8'hE0, 8'hFF);
    rd(uartc_pkg::A_LS, 8'h60, 8'hFF);
    wt(1);
    for (int k = 0; k < 4; k++)
    begin
      wr(uartc_pkg::A_FIFO, {k[1:0], 6'h03});
      wt(1);
      rx(8'h5A, 12'h000);
      cmp_val({11'h0, rx_trigger_out}, {11'h0, k == 0});
    end
    wr(uartc_pkg::A_FIFO, 8'h03);
    wt(3);
    cmp_val({11'h0, rx_trigger_out}, 12'h000);
    rd(uartc_pkg::A_LS, 8'h60, 8'hFF);
    wr(uartc_pkg::A_FIFO, 8'h00);
    wt(2);
    $display("test fifo done");
    results();
  end
endmodule // uartc_core_bench
bind uartc_core uartc_core_properties uartc_core_properties_i (.*);
